// File: ccu_map.vh
// Register offsets, bit positions and reset values of the slow-clock calibration unit
`ifndef CCU_MAP_VH
`define CCU_MAP_VH

`define CCU_ADDR_CONTROL      3'h0
`define CCU_ADDR_RELOAD_LO    3'h1
`define CCU_ADDR_RELOAD_HI    3'h2
`define CCU_ADDR_RESULT_LO    3'h3
`define CCU_ADDR_RESULT_MID   3'h4
`define CCU_ADDR_RESULT_HI    3'h5
`define CCU_ADDR_RESULT_PAD   3'h6

`define CCU_BIT_IRQ_EN        0
`define CCU_BIT_DONE          1
`define CCU_BIT_CLK_SEL       2
`define CCU_BIT_START         4

`define CCU_RELOAD_RESET      16'h8000
`define CCU_RESULT_RESET      24'h000000
`define CCU_SWITCH_MIN_EDGES  2'h3

`endif

// File: ccu_edge_sync.v
// Two-flop synchroniser for a foreign clock pin with a rising-edge tick output
`timescale 1ns/1ps
module ccu_edge_sync (
    input  wire clock_i,
    input  wire srst_i,
    input  wire pin_i,
    output reg  tick_o
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    // Only sync_reg reads meta_reg; the edge detector looks at later stages
    always @(posedge clock_i) begin
        if (srst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            tick_o   <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            tick_o   <= sync_reg & ~last_reg;
        end
    end
endmodule

// File: ccu_slow_select.v
// Slow clock source selector that switches after the old clock has given three edges, or at once if it has given none
`timescale 1ns/1ps
`include "ccu_map.vh"
module ccu_slow_select (
    input  wire clock_i,
    input  wire srst_i,
    input  wire sel_req_i,
    input  wire crystal_tick_i,
    input  wire rc_tick_i,
    output reg  slow_tick_o,
    output reg  sel_active_o
);
    reg [1:0] edges_reg;
    reg       seen_reg;
    wire      cur_tick;

    assign cur_tick = sel_active_o ? rc_tick_i : crystal_tick_i;

    always @(posedge clock_i) begin
        if (srst_i) begin
            edges_reg    <= 2'h0;
            seen_reg     <= 1'b0;
            sel_active_o <= 1'b0;
            slow_tick_o  <= 1'b0;
        end else begin
            slow_tick_o <= cur_tick;
            if (sel_req_i != sel_active_o &&
                (!seen_reg || edges_reg == `CCU_SWITCH_MIN_EDGES)) begin
                sel_active_o <= sel_req_i;
                edges_reg    <= 2'h0;
                seen_reg     <= 1'b0;
            end else if (cur_tick) begin
                seen_reg <= 1'b1;
                if (edges_reg != `CCU_SWITCH_MIN_EDGES) begin
                    edges_reg <= edges_reg + 2'h1;
                end
            end
        end
    end
endmodule

// File: ccu_top.v
// Slow-clock calibration unit: byte registers, duration timer and calibration timer
`timescale 1ns/1ps
`include "ccu_map.vh"
module ccu_top #(
    parameter DUR_W = 16,
    parameter CAL_W = 24
) (
    input  wire       clock_i,
    input  wire       srst_i,
    input  wire [2:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire       rmw_i,
    input  wire       slow_crystal_clock_i,
    input  wire       rc_oscillator_clock_i,
    input  wire       main_oscillator_clock_i,
    output reg  [7:0] rdata_o,
    output reg        irq_o,
    output reg        measure_start_o,
    output reg        slow_clock_active_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ARM  = 2'h1;
    localparam ST_RUN  = 2'h2;
    // Unit steps sized to the counters so no arithmetic widens
    localparam [DUR_W-1:0] DUR_ONE = {{(DUR_W-1){1'b0}}, 1'b1};
    localparam [CAL_W-1:0] CAL_ONE = {{(CAL_W-1){1'b0}}, 1'b1};

    // Sequencer and timers
    reg  [1:0]       state_reg;
    reg  [1:0]       state_next;
    reg              done_reg;
    reg              irq_en_reg;
    reg              clk_sel_reg;
    reg  [DUR_W-1:0] reload_reg;
    reg  [DUR_W-1:0] dur_cnt_reg;
    reg  [DUR_W-1:0] dur_cnt_next;
    reg  [CAL_W-1:0] cal_cnt_reg;
    reg  [CAL_W-1:0] cal_cnt_next;
    reg  [CAL_W-1:0] result_reg;
    // Software-visible read path
    reg  [7:0]       rdata_next;

    // Pin edges as one-cycle ticks, and decoded strobes
    wire crystal_tick;
    wire rc_tick;
    wire main_tick;
    wire slow_tick;
    wire sel_active;
    wire wr_ctrl;
    wire sw_start;
    wire sw_stop;
    wire clr_done;
    wire wr_reload_lo;
    wire wr_reload_hi;
    wire running;
    wire run_slow;
    wire run_main;
    wire arm_go;
    wire complete;
    wire [7:0] result_lo;
    wire [7:0] result_mid;
    wire [7:0] result_hi;

    ccu_edge_sync u_sync_crystal (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .pin_i   (slow_crystal_clock_i),
        .tick_o  (crystal_tick)
    );

    ccu_edge_sync u_sync_rc (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .pin_i   (rc_oscillator_clock_i),
        .tick_o  (rc_tick)
    );

    // The main oscillator must stay well below half this clock for an exact count
    ccu_edge_sync u_sync_main (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .pin_i   (main_oscillator_clock_i),
        .tick_o  (main_tick)
    );

    ccu_slow_select u_select (
        .clock_i        (clock_i),
        .srst_i         (srst_i),
        .sel_req_i      (clk_sel_reg),
        .crystal_tick_i (crystal_tick),
        .rc_tick_i      (rc_tick),
        .slow_tick_o    (slow_tick),
        .sel_active_o   (sel_active)
    );

    assign wr_ctrl      = wr_i && (addr_i == `CCU_ADDR_CONTROL);
    assign sw_start     = wr_ctrl && wdata_i[`CCU_BIT_START];
    assign sw_stop      = wr_ctrl && !wdata_i[`CCU_BIT_START];
    assign clr_done     = wr_ctrl && !wdata_i[`CCU_BIT_DONE];
    assign wr_reload_lo = wr_i && (addr_i == `CCU_ADDR_RELOAD_LO);
    assign wr_reload_hi = wr_i && (addr_i == `CCU_ADDR_RELOAD_HI);
    assign running      = (state_reg != ST_IDLE);

    // Timers move only in RUN, so edges seen while armed are not counted
    assign run_slow = (state_reg == ST_RUN) && slow_tick;
    assign run_main = (state_reg == ST_RUN) && main_tick;
    assign arm_go   = (state_reg == ST_ARM) && slow_tick && !sw_stop;
    assign complete = run_slow && (dur_cnt_reg == DUR_ONE);

    // Result byte lanes
    assign result_lo  = result_reg[7:0];
    assign result_mid = result_reg[15:8];
    assign result_hi  = result_reg[23:16];

    // Measurement sequencer; the timers start on a slow edge so the
    // interval spans whole slow periods
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (sw_start) begin
                    state_next = ST_ARM;
                end
            end
            ST_ARM: begin
                if (sw_stop) begin
                    state_next = ST_IDLE;
                end else if (slow_tick) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // Completion is tested first so a coinciding abort loses
                if (complete) begin
                    state_next = ST_IDLE;
                end else if (sw_stop) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Duration timer; reload zero wraps to all ones first: 65536 ticks
    always @* begin
        dur_cnt_next = dur_cnt_reg;
        if (arm_go) begin
            dur_cnt_next = reload_reg;
        end else if (run_slow) begin
            dur_cnt_next = dur_cnt_reg - DUR_ONE;
        end
    end

    // Calibration timer, restarted from zero at every start
    always @* begin
        cal_cnt_next = cal_cnt_reg;
        if (arm_go) begin
            cal_cnt_next = {CAL_W{1'b0}};
        end else if (run_main) begin
            cal_cnt_next = cal_cnt_reg + CAL_ONE;
        end
    end

    // Sequencer and timer registers
    always @(posedge clock_i) begin
        if (srst_i) begin
            state_reg   <= ST_IDLE;
            dur_cnt_reg <= {DUR_W{1'b0}};
            cal_cnt_reg <= {CAL_W{1'b0}};
        end else begin
            state_reg   <= state_next;
            dur_cnt_reg <= dur_cnt_next;
            cal_cnt_reg <= cal_cnt_next;
        end
    end

    // Only completion writes the result; a main edge on the final slow edge counts
    always @(posedge clock_i) begin
        if (srst_i) begin
            result_reg <= `CCU_RESULT_RESET;
        end else if (complete) begin
            result_reg <= cal_cnt_next;
        end
    end

    // Done flag: only software clears it, and a set beats a simultaneous clear
    always @(posedge clock_i) begin
        if (srst_i) begin
            done_reg <= 1'b0;
        end else if (complete) begin
            done_reg <= 1'b1;
        end else if (clr_done) begin
            done_reg <= 1'b0;
        end
    end

    // Control bits written by software
    always @(posedge clock_i) begin
        if (srst_i) begin
            irq_en_reg  <= 1'b0;
            clk_sel_reg <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_reg  <= wdata_i[`CCU_BIT_IRQ_EN];
            clk_sel_reg <= wdata_i[`CCU_BIT_CLK_SEL];
        end
    end

    // Reload bytes; loaded on leaving ARM, so a write in RUN only affects the next start
    always @(posedge clock_i) begin
        if (srst_i) begin
            reload_reg <= `CCU_RELOAD_RESET;
        end else begin
            if (wr_reload_lo) begin
                reload_reg[7:0] <= wdata_i;
            end
            if (wr_reload_hi) begin
                reload_reg[15:8] <= wdata_i;
            end
        end
    end

    // Read multiplexer; unmapped bytes and undefined control bits read zero
    always @* begin
        rdata_next = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `CCU_ADDR_CONTROL: begin
                    rdata_next[`CCU_BIT_IRQ_EN]  = irq_en_reg;
                    rdata_next[`CCU_BIT_DONE]    = done_reg | rmw_i;
                    rdata_next[`CCU_BIT_CLK_SEL] = clk_sel_reg;
                    rdata_next[`CCU_BIT_START]   = running;
                end
                `CCU_ADDR_RELOAD_LO: begin
                    rdata_next = reload_reg[7:0];
                end
                `CCU_ADDR_RELOAD_HI: begin
                    rdata_next = reload_reg[15:8];
                end
                `CCU_ADDR_RESULT_LO: begin
                    rdata_next = result_lo;
                end
                `CCU_ADDR_RESULT_MID: begin
                    rdata_next = result_mid;
                end
                `CCU_ADDR_RESULT_HI: begin
                    rdata_next = result_hi;
                end
                `CCU_ADDR_RESULT_PAD: begin
                    rdata_next = 8'h00;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // Outputs come straight from flip-flops; irq trails the flag by one cycle
    always @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o             <= 8'h00;
            irq_o               <= 1'b0;
            measure_start_o     <= 1'b0;
            slow_clock_active_o <= 1'b0;
        end else begin
            rdata_o             <= rdata_next;
            irq_o               <= done_reg & irq_en_reg;
            measure_start_o     <= running;
            slow_clock_active_o <= sel_active;
        end
    end
endmodule

// File: ccu_top_asserts.sv
// Port checker for the calibration unit
`timescale 1ns/1ps
module ccu_top_chk (
    input wire       clock_i,
    input wire       srst_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire       rmw_i,
    input wire       slow_crystal_clock_i,
    input wire       rc_oscillator_clock_i,
    input wire       main_oscillator_clock_i,
    input wire [7:0] rdata_o,
    input wire       irq_o,
    input wire       measure_start_o,
    input wire       slow_clock_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    wire cw = wr_i && addr_i == 3'h0;
    wire cr = rd_i && addr_i == 3'h0;
    reg  en_reg;
    reg  sel_reg;
    // Shadows of the interrupt-enable and clock-select bits, since the ports show them only on a control read
    always @(posedge clock_i) begin
        if (srst_i) begin
            en_reg  <= 1'b0;
            sel_reg <= 1'b0;
        end else if (cw) begin
            en_reg  <= wdata_i[0];
            sel_reg <= wdata_i[2];
        end
    end
    rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    start_go_a: assert property (cw && wdata_i[4] && !measure_start_o ##1 !cw |=> measure_start_o)
        else $error("start write did not begin a measurement");
    abort_stop_a: assert property (cw && !wdata_i[4] ##1 !cw |=> !measure_start_o)
        else $error("stop write did not end the measurement");
    ctrl_read_a: assert property (cr |=> rdata_o[4] == measure_start_o && rdata_o[7:5] == 3'h0)
        else $error("control read disagrees with start mirror");
    rmw_done_a: assert property (cr && rmw_i |=> rdata_o[1])
        else $error("modify read of done flag not one");
    irq_mask_a: assert property (!$past(en_reg) |-> !irq_o)
        else $error("interrupt while disabled");
    irq_hold_a: assert property (irq_o && !cw && !$past(cw) |=> irq_o)
        else $error("done flag dropped without a write");
    irq_clear_a: assert property (cw && !wdata_i[1] && !measure_start_o |-> ##2 !irq_o)
        else $error("done flag not cleared by write of zero");
    sel_move_a: assert property ($changed(slow_clock_active_o) |-> slow_clock_active_o == sel_reg)
        else $error("slow clock moved away from the request");
    cover property ($rose(irq_o));
    cover property ($rose(slow_clock_active_o));
    cover property (cr && rmw_i);
endmodule
bind ccu_top ccu_top_chk u_chk (.*);

// File: ccu_top_tb_top.sv
// Self-checking testbench for the calibration unit
`timescale 1ns/1ps
module ccu_top_tb_top;
    typedef struct {logic [7:0] v; int t;} ccu_exp_t;
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [2:0]  addr_i = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rmw_i = 1'b0;
    logic        slow_crystal_clock_i = 1'b0;
    logic        rc_oscillator_clock_i = 1'b0;
    logic        main_oscillator_clock_i = 1'b0;
    logic        rc_run = 1'b0;
    wire [7:0]   rdata_o;
    wire         irq_o;
    wire         measure_start_o;
    wire         slow_clock_active_o;
    ccu_exp_t    q[$];
    ccu_exp_t    e;
    logic        rd_seen = 1'b0;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    logic [15:0] rl;
    logic [7:0]  res;
    always #10 clock_i = ~clock_i;
    always #200 slow_crystal_clock_i = ~slow_crystal_clock_i;
    always #150 if (rc_run) rc_oscillator_clock_i = ~rc_oscillator_clock_i;
    always #50 main_oscillator_clock_i = ~main_oscillator_clock_i;
    ccu_top u_dut (.*);
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic g, input logic x);
        compares++;
        if (g !== x) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Read answers land one cycle after the strobe, so the monitor trails by one edge
    always @(posedge clock_i) begin
        if (rd_seen) begin
            e = q.pop_front();
            compares++;
            if (rdata_o !== e.v && !(e.t > 0 && (rdata_o === e.v + 8'h01 || rdata_o === e.v - 8'h01))) begin
                bad_count++;
                $display("Error at %0t: got %h expected %h", $time, rdata_o, e.v);
            end
        end
        rd_seen <= rd_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic wr(input [2:0] a, input [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input [2:0] a, input [7:0] v, input int t, input logic m);
        q.push_back('{v, t});
        addr_i <= a;
        rd_i <= 1'b1;
        rmw_i <= m;
        @(posedge clock_i);
        rd_i <= 1'b0;
        rmw_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wait_sel(input logic v);
        for (int n = 0; n < 300 && slow_clock_active_o !== v; n++) @(posedge clock_i);
    endtask
    task automatic meas(input [7:0] c, input [7:0] m, input int p);
        time t0;
        rl = 16'(4 + $urandom % 12);
        wr(3'h1, rl[7:0]);
        wr(3'h2, 8'h00);
        rd(3'h1, rl[7:0], 0, 1'b0);
        t0 = $time;
        wr(3'h0, c);
        rd(3'h0, m, 0, 1'b0);
        for (int n = 0; n < 3000 && measure_start_o !== 1'b0; n++) @(posedge clock_i);
        @(posedge clock_i);
        chk(measure_start_o, 1'b0);
        chk($time - t0 < (rl + 3) * p, 1'b1);
        res = 8'(rl * p / 100);
        rd(3'h3, res, 1, 1'b0);
        rd(3'h4, 8'h00, 0, 1'b0);
        rd(3'h5, 8'h00, 0, 1'b0);
    endtask
    initial begin
        void'($urandom(15031));
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        rd(3'h2, 8'h80, 0, 1'b0);
        for (int a = 0; a < 8; a++) if (a != 2) rd(3'(a), 8'h00, 0, 1'b0);
        $display("reset values done");
        meas(8'h11, 8'h11, 400);
        rd(3'h0, 8'h03, 0, 1'b0);
        chk(irq_o, 1'b1);
        for (int a = 3; a < 7; a++) wr(3'(a), 8'($urandom));
        rd(3'h3, res, 1, 1'b0);
        $display("measurement with interrupt done");
        wr(3'h0, 8'h03);
        rd(3'h0, 8'h03, 0, 1'b0);
        wr(3'h0, 8'h01);
        rd(3'h0, 8'h01, 0, 1'b0);
        chk(irq_o, 1'b0);
        rd(3'h0, 8'h03, 0, 1'b1);
        wr(3'h0, 8'h03);
        rd(3'h0, 8'h01, 0, 1'b0);
        $display("done flag access done");
        meas(8'h10, 8'h10, 400);
        rd(3'h0, 8'h02, 0, 1'b0);
        chk(irq_o, 1'b0);
        meas(8'h12, 8'h12, 400);
        $display("disabled interrupt done");
        wr(3'h0, 8'h10);
        repeat (30) @(posedge clock_i);
        wr(3'h0, 8'h10);
        rd(3'h0, 8'h10, 0, 1'b0);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h00, 0, 1'b0);
        repeat (600) @(posedge clock_i);
        rd(3'h0, 8'h00, 0, 1'b0);
        rd(3'h3, res, 1, 1'b0);
        $display("abort done");
        wr(3'h0, 8'h04);
        wait_sel(1'b1);
        chk(slow_clock_active_o, 1'b1);
        rc_oscillator_clock_i <= 1'b1;
        repeat (15) @(posedge clock_i);
        rc_oscillator_clock_i <= 1'b0;
        repeat (15) @(posedge clock_i);
        wr(3'h0, 8'h00);
        repeat (100) @(posedge clock_i);
        chk(slow_clock_active_o, 1'b1);
        rc_run = 1'b1;
        wait_sel(1'b0);
        chk(slow_clock_active_o, 1'b0);
        wr(3'h0, 8'h04);
        wait_sel(1'b1);
        meas(8'h14, 8'h14, 300);
        rd(3'h0, 8'h06, 0, 1'b0);
        $display("clock select done");
        conclude();
    end
endmodule
